/* hdl/dct_pkg.sv */
// Package for the DDR2 device-side command timing block.
// Assumes one 200 MHz clock; all counts except the termination turn-off delay (half clocks) are in clock cycles of that clock.
package dct_pkg;

	// ------------------------------------------------------------
	// Geometry and encodings
	// ------------------------------------------------------------
	localparam int NUM_BANKS   = 8;
	localparam int BANK_W      = 3;
	localparam int CNT_W       = 8;
	localparam int CLK_PERIOD_PS = 5000;

	// Row active time and internal read-to-precharge time, in ps
	localparam int ROW_ACTIVE_TIME_PS         = 40000;
	localparam int READ_TO_PRECHARGE_TIME_PS  = 7500;
	localparam logic [CNT_W-1:0] ROW_ACTIVE_CYC =
		CNT_W'((ROW_ACTIVE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] READ_TO_PRE_CYC =
		CNT_W'((READ_TO_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// Termination delays in whole clocks; the turn-off delay is 2.5 clocks,
	// counted in half clocks
	localparam logic [3:0] TERM_ON_DELAY_CYC  = 4'h2;
	localparam logic [3:0] TERM_ON_SPAN_CYC   = 4'h1;
	localparam logic [3:0] TERM_OFF_HALF_CYC  = 4'h5;

	// Extended mode register field positions
	localparam int EMR_TERM_HI_BIT = 6;
	localparam int EMR_TERM_LO_BIT = 2;

	// Mode register field: write recovery clocks at bits 9..11
	localparam int MR_WR_LSB = 9;

	// Command encodings as seen by the block
	typedef enum logic [3:0] {
		DCT_NOP, DCT_ACT, DCT_RD, DCT_WR, DCT_RDA, DCT_WRA,
		DCT_PRE, DCT_PREA, DCT_REF, DCT_MRS, DCT_EMRS
	} dct_cmd_e;

	typedef enum logic [1:0] {
		DCT_RTT_OFF, DCT_RTT_75, DCT_RTT_150, DCT_RTT_50
	} dct_rtt_e;

	typedef struct packed {
		dct_cmd_e            cmd;
		logic [BANK_W-1:0]   bank;
		logic [13:0]         addr;
	} dct_cmd_s;

	typedef struct packed {
		logic     partial;  // Termination ramping or fully on
		logic     full;     // Termination fully on
		dct_rtt_e value;
	} dct_term_s;

endpackage

/* hdl/dct_bank.sv */
// One bank's row state and delayed internal precharge.
// Assumes commands arrive one per clock, already decoded for this bank.
`timescale 1ns/1ps
module dct_bank (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      activate,
	input  wire logic                      readCmd,
	input  wire logic                      writeCmd,
	input  wire logic                      autoPre,
	input  wire logic                      explicitPre,
	input  wire logic [dct_pkg::CNT_W-1:0] burstHalf,
	input  wire logic [dct_pkg::CNT_W-1:0] wrRecovery,
	output logic                           rowOpen,
	output logic                           internalPre
);
	import dct_pkg::*;

	typedef struct packed {
		logic             open;
		logic             pending;
		logic             pre;
		logic [CNT_W-1:0] rasCnt;
		logic [CNT_W-1:0] waitCnt;
	} dct_bank_s;

	dct_bank_s st_q, st_d;
	logic      rasMet;

	always_comb begin
		st_d = st_q;
		st_d.pre = 1'b0;
		rasMet = (st_q.rasCnt >= ROW_ACTIVE_CYC);
		if (st_q.open && !rasMet) begin
			st_d.rasCnt = st_q.rasCnt + 8'h01;
		end
		if (st_q.waitCnt != 8'h00) begin
			st_d.waitCnt = st_q.waitCnt - 8'h01;
		end
		if (activate) begin
			st_d.open    = 1'b1;
			st_d.rasCnt  = 8'h01;
			st_d.pending = 1'b0;
		end
		// Auto-precharge is taken before row active time is met
		if ((readCmd || writeCmd) && autoPre && st_q.open) begin
			st_d.pending = 1'b1;
			st_d.waitCnt = readCmd ? ((burstHalf > READ_TO_PRE_CYC) ? burstHalf
				: READ_TO_PRE_CYC) : CNT_W'(burstHalf + wrRecovery);
		end
		// Internal precharge waits for both delay and row active time
		if (st_q.pending && st_q.waitCnt == 8'h00 && rasMet) begin
			st_d.pending = 1'b0;
			st_d.open    = 1'b0;
			st_d.pre     = 1'b1;
		end
		if (explicitPre) begin
			st_d.open    = 1'b0;
			st_d.pending = 1'b0;
		end
		if (!rstn) begin
			st_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign rowOpen     = st_q.open;
	assign internalPre = st_q.pre;
endmodule

/* hdl/dct_top.sv */
// Device-side DDR2 command timing block: bank state, termination timing.
// Assumes the controller keeps activate, precharge, refresh and clock
// enable spacing; commands arrive decoded and synchronous to clk.
`timescale 1ns/1ps
module dct_top (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 clkEnable,
	input  wire dct_pkg::dct_cmd_s    cmdIn,
	input  wire logic                 termEnable,
	output dct_pkg::dct_term_s        termState,
	output logic [dct_pkg::NUM_BANKS-1:0] bankOpen,
	output logic [dct_pkg::NUM_BANKS-1:0] bankInternalPre,
	output logic [15:0]               refreshCount
);
	import dct_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum {TS_OFF, TS_ON_WAIT, TS_RAMP, TS_ON, TS_OFF_WAIT} dct_tstate_e;

	typedef struct packed {
		logic [CNT_W-1:0] burstHalf;
		logic [CNT_W-1:0] wrRecovery;
		dct_rtt_e         rtt;
		logic [3:0]       tcnt;
		logic             partial;
		logic             full;
		logic [15:0]      refCnt;
	} dct_top_s;

	dct_top_s    st_q, st_d;
	dct_tstate_e ts_q, ts_d;
	dct_cmd_s    cmd;

	// Commands are only registered while clock enable is high
	always_comb begin
		cmd = cmdIn;
		if (!clkEnable) begin
			cmd.cmd = DCT_NOP;
		end
	end

	// ------------------------------------------------------------
	// Banks
	// ------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			logic hit;
			assign hit = (cmd.bank == BANK_W'(gb));
			dct_bank u_bank (
				.clk         (clk),
				.rstn        (rstn),
				.activate    (hit && cmd.cmd == DCT_ACT),
				.readCmd     (hit && (cmd.cmd == DCT_RDA)),
				.writeCmd    (hit && (cmd.cmd == DCT_WRA)),
				.autoPre     (1'b1),
				.explicitPre ((hit && cmd.cmd == DCT_PRE) || cmd.cmd == DCT_PREA),
				.burstHalf   (st_q.burstHalf),
				.wrRecovery  (st_q.wrRecovery),
				.rowOpen     (bankOpen[gb]),
				.internalPre (bankInternalPre[gb])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Mode registers, refresh, termination
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		ts_d = ts_q;
		if (cmd.cmd == DCT_MRS) begin
			// Burst of 8 when bit 1 set, else 4; half burst in clocks
			st_d.burstHalf  = cmd.addr[1] ? 8'h04 : 8'h02;
			st_d.wrRecovery = CNT_W'(cmd.addr[MR_WR_LSB +: 3]) + 8'h01;
		end
		if (cmd.cmd == DCT_EMRS) begin
			st_d.rtt = dct_rtt_e'({cmd.addr[EMR_TERM_HI_BIT],
				cmd.addr[EMR_TERM_LO_BIT]});
		end
		// No minimum spacing: every refresh counts
		if (cmd.cmd == DCT_REF) begin
			st_d.refCnt = st_q.refCnt + 16'h0001;
		end
		if (st_q.tcnt != 4'h0) begin
			st_d.tcnt = st_q.tcnt - 4'h1;
		end
		unique case (ts_q)
			TS_OFF: begin
				if (termEnable) begin
					ts_d = TS_ON_WAIT;
					st_d.tcnt = TERM_ON_DELAY_CYC - 4'h1;
				end
			end
			TS_ON_WAIT: begin
				if (st_q.tcnt == 4'h0) begin
					ts_d = TS_RAMP;
					st_d.partial = 1'b1;
					st_d.tcnt = TERM_ON_SPAN_CYC - 4'h1;
				end
			end
			TS_RAMP: begin
				if (st_q.tcnt == 4'h0) begin
					ts_d = TS_ON;
					st_d.full = 1'b1;
				end
			end
			TS_ON: begin
				if (!termEnable) begin
					ts_d = TS_OFF_WAIT;
					// Half clocks rounded down to the earlier whole edge: limitation of half a clock
					st_d.tcnt = (TERM_OFF_HALF_CYC >> 1) - 4'h1;
				end
			end
			TS_OFF_WAIT: begin
				if (st_q.tcnt == 4'h0) begin
					ts_d = TS_OFF;
					st_d.full = 1'b0;
					st_d.partial = 1'b0;
				end
			end
		endcase
		if (!rstn) begin
			st_d = '0;
			ts_d = TS_OFF;
			st_d.burstHalf  = 8'h02;
			st_d.wrRecovery = 8'h02;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
		ts_q <= ts_d;
	end

	// One driver for the whole struct; the value reads off while nothing is enabled
	assign termState = '{partial: st_q.partial, full: st_q.full,
		value: (st_q.partial || st_q.full) ? st_q.rtt : DCT_RTT_OFF};
	assign refreshCount      = st_q.refCnt;
endmodule

/* testbench/dct_ctrl_model.sv */
// Controller-side model that drives commands, clock enable and termination.
// Assumes the bench calls its tasks; every input changes at a rising edge.
`timescale 1ns/1ps
module dct_ctrl_model
	import dct_pkg::*;
(
	input  wire logic clk,
	output dct_cmd_s  cmdIn,
	output logic      clkEnable,
	output logic      termEnable
);
	initial begin
		cmdIn = '0;
		clkEnable = 1'b0;
		termEnable = 1'b0;
	end
	// ------------------------------------------------------------
	// Command issue
	// ------------------------------------------------------------
	// Repeats the same command n times back to back; caller keeps bank spacing
	task automatic issue(input dct_cmd_e c, input logic [2:0] b, input logic [13:0] a,
		input int n = 1);
		repeat (n) @(posedge clk) cmdIn <= '{cmd: c, bank: b, addr: a};
		@(posedge clk) cmdIn <= '0;
	endtask
	// Held for three sampled edges before anything else may change it
	task automatic setCke(input logic v);
		@(posedge clk) clkEnable <= v;
		repeat (3) @(posedge clk);
	endtask
	task automatic setTerm(input logic v);
		@(posedge clk) termEnable <= v;
	endtask
endmodule

/* testbench/dct_top_asserts.sv */
// Port-level timing checks for the command timing block.
// Assumes a bind into every instance of dct_top.
`timescale 1ns/1ps
module dct_top_asserts
	import dct_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire logic                 clkEnable,
	input wire dct_cmd_s             cmdIn,
	input wire logic                 termEnable,
	input wire dct_term_s            termState,
	input wire logic [NUM_BANKS-1:0] bankOpen,
	input wire logic [NUM_BANKS-1:0] bankInternalPre,
	input wire logic [15:0]          refreshCount
);
	import dct_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_act_opens_row: assert property (clkEnable && cmdIn.cmd == DCT_ACT
		|=> bankOpen[$past(cmdIn.bank)]) else $error("row not open after activate");
	chk_refresh_counts: assert property (clkEnable && cmdIn.cmd == DCT_REF
		|=> refreshCount == $past(refreshCount) + 16'h1) else $error("refresh lost");
	chk_refresh_holds: assert property (!(clkEnable && cmdIn.cmd == DCT_REF)
		|=> $stable(refreshCount)) else $error("refresh count moved");
	chk_pre_after_ras: assert property (bankInternalPre[0]
		|-> $past(bankOpen[0], 8)) else $error("internal precharge too early");
	chk_pre_closes_row: assert property (bankInternalPre[0]
		|-> !bankOpen[0] ##1 !bankInternalPre[0]) else $error("precharge pulse wrong");
	chk_term_on_time: assert property ($rose(termEnable)
		|-> ##3 termState.partial ##1 termState.full) else $error("termination on late");
	chk_term_off_time: assert property ($fell(termEnable) && termState.full
		|-> ##1 termState.full ##1 termState.full
		##1 !termState.full && !termState.partial)
		else $error("termination off wrong");
	chk_term_value_off: assert property (!termState.partial && !termState.full
		|-> termState.value == DCT_RTT_OFF) else $error("value while off");
endmodule
bind dct_top dct_top_asserts chk (.clk(clk), .rstn(rstn), .clkEnable(clkEnable),
	.cmdIn(cmdIn), .termEnable(termEnable), .termState(termState), .bankOpen(bankOpen),
	.bankInternalPre(bankInternalPre), .refreshCount(refreshCount));

/* testbench/tb_top.sv */
// Self-checking bench for the command timing block.
// Assumes the controller model drives all inputs except clock and reset.
`timescale 1ns/1ps
`define CHK(a, e, m) begin nCompared++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
	import dct_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	int miscompares = 0;
	int nCompared = 0;
	dct_cmd_s cmdIn;
	logic clkEnable, termEnable;
	dct_term_s termState;
	logic [NUM_BANKS-1:0] bankOpen, bankInternalPre;
	logic [15:0] refreshCount;
	initial forever #2.5 clk = ~clk;
	dct_ctrl_model ctrl (.clk(clk), .cmdIn(cmdIn), .clkEnable(clkEnable), .termEnable(termEnable));
	dct_top DUT (.clk(clk), .rstn(rstn), .clkEnable(clkEnable), .cmdIn(cmdIn),
		.termEnable(termEnable), .termState(termState), .bankOpen(bankOpen),
		.bankInternalPre(bankInternalPre), .refreshCount(refreshCount));
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_refresh();
		ctrl.issue(DCT_REF, 3'h0, 14'h0, 4);
		#1 `CHK(refreshCount, 16'h0004, "burst refresh")
		// Commands while clock enable is low must not count
		ctrl.setCke(1'b0);
		ctrl.issue(DCT_REF, 3'h0, 14'h0, 2);
		#1 `CHK(refreshCount, 16'h0004, "refresh with cke low")
		ctrl.setCke(1'b1);
		$display("t_refresh done");
	endtask
	task automatic t_autopre();
		int cyc;
		dct_cmd_e cmds[3] = '{DCT_RDA, DCT_WRA, DCT_WRA};
		// Last case: burst 8 and recovery field 5 (six clocks) outlast row active time
		int expCyc[3] = '{8, 8, 13};
		for (int i = 0; i < 3; i++) begin
			if (i == 2) begin
				ctrl.issue(DCT_MRS, 3'h0, 14'h0a02);
			end
			ctrl.issue(DCT_ACT, 3'h0, 14'h0);
			ctrl.issue(cmds[i], 3'h0, 14'h0);
			#1 `CHK(bankOpen[0], 1'b1, "row closed early")
			cyc = 2;
			while (bankInternalPre[0] !== 1'b1 && cyc < 40) begin
				@(posedge clk);
				#1 cyc++;
			end
			`CHK(cyc, expCyc[i], "internal precharge time")
			`CHK(bankOpen[0], 1'b0, "row not closed")
		end
		$display("t_autopre done");
	endtask
	task automatic t_term();
		for (int c = 0; c < 4; c++) begin
			ctrl.issue(DCT_EMRS, 3'h0, (14'(c >> 1) << 6) | (14'(c & 1) << 2));
			ctrl.setTerm(1'b1);
			repeat (4) @(posedge clk);
			#1 `CHK(termState.value, dct_rtt_e'(c), "termination value")
			ctrl.setTerm(1'b0);
			repeat (3) @(posedge clk);
			#1 `CHK(termState.full, 1'b0, "termination still on")
			`CHK(termState.value, DCT_RTT_OFF, "value after off")
		end
		$display("t_term done");
	endtask
	task automatic t_precharge();
		logic [NUM_BANKS-1:0] seen;
		seen = '0;
		ctrl.issue(DCT_ACT, 3'h1, 14'h0);
		ctrl.issue(DCT_ACT, 3'h2, 14'h0);
		ctrl.issue(DCT_ACT, 3'h3, 14'h0);
		#1 `CHK(bankOpen, 8'h0e, "rows opened")
		ctrl.issue(DCT_PRE, 3'h1, 14'h0);
		#1 `CHK(bankOpen, 8'h0c, "single bank precharge")
		// Auto-precharge to a closed bank must be ignored
		ctrl.issue(DCT_RDA, 3'h4, 14'h0);
		repeat (12) begin
			@(posedge clk);
			#1 seen |= bankInternalPre;
		end
		`CHK({bankOpen, seen}, 16'h0c00, "auto-precharge on closed bank")
		ctrl.issue(DCT_PREA, 3'h0, 14'h0);
		#1 `CHK(bankOpen, 8'h00, "precharge all")
		$display("t_precharge done");
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		#1 `CHK({bankOpen, bankInternalPre, refreshCount}, 32'h0, "reset values")
		ctrl.setCke(1'b1);
		t_refresh();
		t_autopre();
		t_precharge();
		t_term();
		end_of_test();
	end
endmodule
